// >>> mgmt_host.sv
// host controller model: single-word reads and writes
// assumes strobes sampled at rising mclk
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
  input wire logic mclk,
  output logic [15:0] reg_addr = 16'h0000,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  // released lines show the inverse so stale values never match
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // answer stands one cycle later; a missing valid returns the inverse
    @(posedge mclk);
    q = reg_rvalid ? reg_rdata : ~reg_rdata;
  endtask : rd
endmodule : mgmt_host
`default_nettype wire

// >>> rx_mon_checker_props.sv
// checker for the register port and monitor captures
// assumes one mclk domain with rst asynchronous, active high
`timescale 1ns/1ps
`default_nettype none
module rx_mon_checker #(
  parameter logic [15:0] CODE_MIN_ATTEN_0 = 16'h0000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic meas_valid,
  input wire logic [7:0][15:0] diode_meas,
  input wire logic [15:0] temp_meas,
  input wire logic [1:0] attenuation_closed_loop_enable,
  input wire logic [1:0][15:0] loop_drive,
  input wire logic [1:0][15:0] atten_dac_code
);
  logic [15:0] tl_r;
  logic [15:0] dl_r;
  logic [15:0] cl_r;
  logic [16:0] c_sum;
  logic [15:0] ld0;
  logic en0;
  assign c_sum = {1'b0, diode_meas[0]} + {1'b0, diode_meas[1]};
  assign ld0 = loop_drive[0];
  assign en0 = attenuation_closed_loop_enable[0];
  // last captured sample, so reads long after capture are still checked
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tl_r <= 16'h0000;
      dl_r <= 16'h0000;
      cl_r <= 16'h0000;
    end
    else if (meas_valid)
    begin
      tl_r <= temp_meas;
      dl_r <= diode_meas[0];
      cl_r <= c_sum[16] ? 16'hffff : c_sum[15:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rvalid_follows_rd: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer timing wrong");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_drive_zero_min: assert property (reg_wr && reg_addr == 16'hbb9f && reg_wdata == 16'h0000 && !en0 ##1 !en0
    |=> atten_dac_code[0] == CODE_MIN_ATTEN_0)
    else $error("zero drive not least attenuation");
  a_code_min_read: assert property (reg_rd && reg_addr == 16'hbba1 |=> reg_rdata == CODE_MIN_ATTEN_0)
    else $error("min attenuation code wrong");
  a_diode_now_read: assert property (reg_rd && reg_addr == 16'hbba5 |=> reg_rdata == $past(dl_r))
    else $error("diode current wrong");
  a_chan_now_read: assert property (reg_rd && reg_addr == 16'hbbb5 |=> reg_rdata == $past(cl_r))
    else $error("channel current wrong");
  a_temp_now_read: assert property (reg_rd && reg_addr == 16'hbbc5 |=> reg_rdata == $past(tl_r))
    else $error("temperature wrong");
  a_loop_owns_drive: assert property (en0 && $past(en0) && $stable(ld0) && reg_rd && reg_addr == 16'hbb9f
    |=> reg_rdata == $past(ld0))
    else $error("drive not loop value");
endmodule : rx_mon_checker
bind rx_optical_monitor_regs rx_mon_checker #(.CODE_MIN_ATTEN_0(CODE_MIN_ATTEN_0)) chk (.mclk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .meas_valid, .diode_meas, .temp_meas,
  .attenuation_closed_loop_enable, .loop_drive, .atten_dac_code);
`default_nettype wire

// >>> rx_mon_pkg.sv
// receive optical monitor register bank: constants, offsets, reset values
// assumes a 16-bit management register port in front of this bank
package rx_mon_pkg;

  localparam int DW = 16;
  localparam int N_ATT = 2;
  localparam int N_PD = 8;
  localparam int N_CH = 4;
  localparam int N_POL = 2;
  // lanes of the statistics engines, one engine per lane: atten, diodes, channels, polarizations
  localparam int L_ATT = 0;
  localparam int L_PD = 2;
  localparam int L_CH = 10;
  localparam int L_POL = 14;
  localparam int N_LANE = 16;

  localparam logic [15:0] ADDR_ATTEN_MAX_PM = 16'hbb9d;
  localparam logic [15:0] ADDR_DRIVE_SIGNAL = 16'hbb9f;
  localparam logic [15:0] ADDR_CODE_MIN_ATTEN = 16'hbba1;
  localparam logic [15:0] ADDR_CODE_MAX_ATTEN = 16'hbba3;
  localparam logic [15:0] ADDR_DIODE_NOW = 16'hbba5;
  localparam logic [15:0] ADDR_DIODE_AVG_PM = 16'hbbad;
  localparam logic [15:0] ADDR_CHAN_NOW = 16'hbbb5;
  localparam logic [15:0] ADDR_CHAN_AVG_PM = 16'hbbb9;
  localparam logic [15:0] ADDR_POLAR_NOW = 16'hbbbd;
  localparam logic [15:0] ADDR_POLAR_AVG_PM = 16'hbbbf;
  localparam logic [15:0] ADDR_POLAR_MIN_PM = 16'hbbc1;
  localparam logic [15:0] ADDR_POLAR_MAX_PM = 16'hbbc3;
  localparam logic [15:0] ADDR_TEMPERATURE = 16'hbbc5;

  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;
  localparam logic [15:0] SAT_MAX = 16'hffff;
  // plain defaults for the attenuator converter endpoints
  localparam logic [15:0] DEF_CODE_MIN_ATTEN = 16'h0000;
  localparam logic [15:0] DEF_CODE_MAX_ATTEN = 16'hffff;

  // running average: x/16 weight per sample, 4 fraction bits kept
  localparam int EMA_SHIFT = 4;
  localparam int EMA_W = DW + EMA_SHIFT;

endpackage : rx_mon_pkg

// >>> rx_optical_monitor_regs.sv
// receive optical monitor register bank with interval statistics
// drive registers feed the attenuator converter; all other registers are read-only
// assumes measurements and strobes come from logic on mclk; a 16-bit
// management register port (frame decoding lives upstream) reaches it
`timescale 1ns/1ps
`default_nettype none

module rx_optical_monitor_regs #(
  parameter logic [15:0] CODE_MIN_ATTEN_0 = rx_mon_pkg::DEF_CODE_MIN_ATTEN,
  parameter logic [15:0] CODE_MIN_ATTEN_1 = rx_mon_pkg::DEF_CODE_MIN_ATTEN,
  parameter logic [15:0] CODE_MAX_ATTEN_0 = rx_mon_pkg::DEF_CODE_MAX_ATTEN,
  parameter logic [15:0] CODE_MAX_ATTEN_1 = rx_mon_pkg::DEF_CODE_MAX_ATTEN
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [rx_mon_pkg::DW-1:0] reg_wdata,
  output logic [rx_mon_pkg::DW-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic meas_valid,
  input wire logic [rx_mon_pkg::N_ATT-1:0][rx_mon_pkg::DW-1:0] atten_meas,
  input wire logic [rx_mon_pkg::N_PD-1:0][rx_mon_pkg::DW-1:0] diode_meas,
  input wire logic [rx_mon_pkg::DW-1:0] temp_meas,
  input wire logic performance_monitor_interval,
  input wire logic [rx_mon_pkg::N_ATT-1:0] attenuation_closed_loop_enable,
  input wire logic [rx_mon_pkg::N_ATT-1:0][rx_mon_pkg::DW-1:0] loop_drive,
  output logic [rx_mon_pkg::N_ATT-1:0][rx_mon_pkg::DW-1:0] atten_dac_code
);
  import rx_mon_pkg::*;

  // ----------------------------------------------------------------
  // present values
  // ----------------------------------------------------------------
  // lane buses gather per-lane flops by continuous assigns, so every flop keeps a single writer
  wire [N_LANE-1:0][DW-1:0] lane_in;
  wire [N_LANE-1:0][DW-1:0] now_r;
  logic [DW-1:0] temp_r;
  wire [N_LANE-1:0][DW-1:0] avg_pm_r;
  wire [N_LANE-1:0][DW-1:0] min_pm_r;
  wire [N_LANE-1:0][DW-1:0] max_pm_r;

  genvar g;
  generate
    for (g = 0; g < N_ATT; g++)
    begin : g_att_in
      assign lane_in[L_ATT+g] = atten_meas[g];
    end
    for (g = 0; g < N_PD; g++)
    begin : g_pd_in
      assign lane_in[L_PD+g] = diode_meas[g];
    end
    // channel sums its positive and negative diode, saturating
    // a saturated sum reads full scale instead of wrapping to a small current
    for (g = 0; g < N_CH; g++)
    begin : g_ch_in
      wire [DW:0] ch_sum;
      assign ch_sum = {1'b0, diode_meas[2*g]} + {1'b0, diode_meas[2*g+1]};
      assign lane_in[L_CH+g] = ch_sum[DW] ? SAT_MAX : ch_sum[DW-1:0];
    end
    // polarization sums its I and Q channel
    for (g = 0; g < N_POL; g++)
    begin : g_pol_in
      wire [DW:0] pol_sum;
      assign pol_sum = {1'b0, lane_in[L_CH+2*g]} + {1'b0, lane_in[L_CH+2*g+1]};
      assign lane_in[L_POL+g] = pol_sum[DW] ? SAT_MAX : pol_sum[DW-1:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // temperature
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      temp_r <= RESET_VALUE;
    end
    else if (meas_valid)
    begin
      temp_r <= temp_meas;
    end
  end

  // ----------------------------------------------------------------
  // interval statistics, one engine per lane
  // ----------------------------------------------------------------
  // a sample arriving on the boundary cycle opens the new interval
  generate
    for (g = 0; g < N_LANE; g++)
    begin : g_stat
      logic [DW-1:0] cur_r;
      logic [EMA_W-1:0] ema_r;
      logic [DW-1:0] run_min_r;
      logic [DW-1:0] run_max_r;
      logic seen_r;
      logic [DW-1:0] avg_r;
      logic [DW-1:0] lo_r;
      logic [DW-1:0] hi_r;
      wire [DW-1:0] x = lane_in[g];
      wire signed [EMA_W:0] ema_diff = $signed({1'b0, x, {EMA_SHIFT{1'b0}}}) - $signed({1'b0, ema_r});
      wire signed [EMA_W:0] ema_step = ema_diff >>> EMA_SHIFT;
      wire [EMA_W-1:0] ema_upd = EMA_W'(ema_r + ema_step[EMA_W-1:0]);
      wire [DW-1:0] min_upd = (!seen_r || x < run_min_r) ? x : run_min_r;
      wire [DW-1:0] max_upd = (!seen_r || x > run_max_r) ? x : run_max_r;
      wire pm_edge = performance_monitor_interval;
      // the average is never cleared, so it keeps smoothing across boundaries
      wire [DW-1:0] cur_nxt = meas_valid ? x : cur_r;
      wire [EMA_W-1:0] ema_nxt = meas_valid ? ema_upd : ema_r;
      // extremes restart from the boundary sample; a clear seen_r marks an empty interval
      wire [DW-1:0] run_min_nxt = pm_edge ? x : meas_valid ? min_upd : run_min_r;
      wire [DW-1:0] run_max_nxt = pm_edge ? x : meas_valid ? max_upd : run_max_r;
      wire seen_nxt = pm_edge ? meas_valid : (seen_r || meas_valid);
      wire [DW-1:0] avg_nxt = pm_edge ? ema_r[EMA_W-1:EMA_SHIFT] : avg_r;
      wire [DW-1:0] lo_nxt = pm_edge ? (seen_r ? run_min_r : RESET_VALUE) : lo_r;
      wire [DW-1:0] hi_nxt = pm_edge ? (seen_r ? run_max_r : RESET_VALUE) : hi_r;

      // sample path
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          cur_r <= RESET_VALUE;
          ema_r <= '0;
        end
        else
        begin
          cur_r <= cur_nxt;
          ema_r <= ema_nxt;
        end
      end

      // running extremes of the open interval
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          run_min_r <= RESET_VALUE;
          run_max_r <= RESET_VALUE;
          seen_r <= 1'b0;
        end
        else
        begin
          run_min_r <= run_min_nxt;
          run_max_r <= run_max_nxt;
          seen_r <= seen_nxt;
        end
      end

      // results of the closed interval
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          avg_r <= RESET_VALUE;
          lo_r <= RESET_VALUE;
          hi_r <= RESET_VALUE;
        end
        else
        begin
          avg_r <= avg_nxt;
          lo_r <= lo_nxt;
          hi_r <= hi_nxt;
        end
      end

      assign now_r[g] = cur_r;
      assign avg_pm_r[g] = avg_r;
      assign min_pm_r[g] = lo_r;
      assign max_pm_r[g] = hi_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // attenuator drive
  // ----------------------------------------------------------------
  logic [N_ATT-1:0][DW-1:0] drive_r;
  wire [N_ATT-1:0][DW-1:0] drive_nxt;
  wire [N_ATT-1:0][DW-1:0] code_nxt;
  wire [N_ATT-1:0][DW-1:0] code_min = {CODE_MIN_ATTEN_1, CODE_MIN_ATTEN_0};
  wire [N_ATT-1:0][DW-1:0] code_max = {CODE_MAX_ATTEN_1, CODE_MAX_ATTEN_0};

  generate
    for (g = 0; g < N_ATT; g++)
    begin : g_drive
      wire wr_hit = reg_wr && (reg_addr == 16'(ADDR_DRIVE_SIGNAL + g));
      wire up = code_max[g] >= code_min[g];
      wire [DW-1:0] span = up ? DW'(code_max[g] - code_min[g]) : DW'(code_min[g] - code_max[g]);
      // full drive scale spans the converter range; one count never exceeds one code step
      wire [2*DW-1:0] scaled = drive_r[g] * span;
      wire [DW-1:0] offs = scaled[2*DW-1:DW];
      // the closed loop owns the drive; a host write that meets it is dropped
      assign drive_nxt[g] = attenuation_closed_loop_enable[g] ? loop_drive[g] :
        wr_hit ? reg_wdata : drive_r[g];
      assign code_nxt[g] = up ? DW'(code_min[g] + offs) : DW'(code_min[g] - offs);
    end
  endgenerate

  // drive registers, one writer for both instances
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      drive_r <= {N_ATT{RESET_VALUE}};
    end
    else
    begin
      drive_r <= drive_nxt;
    end
  end

  // converter code lags the drive register by one cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      atten_dac_code <= {N_ATT{DEF_CODE_MIN_ATTEN}};
    end
    else
    begin
      atten_dac_code <= code_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // writes outside the drive pair fall through untouched
  wire [15:0] o_att = 16'(reg_addr - ADDR_ATTEN_MAX_PM);
  wire [15:0] o_drv = 16'(reg_addr - ADDR_DRIVE_SIGNAL);
  wire [15:0] o_cmin = 16'(reg_addr - ADDR_CODE_MIN_ATTEN);
  wire [15:0] o_cmax = 16'(reg_addr - ADDR_CODE_MAX_ATTEN);
  wire [15:0] o_pdn = 16'(reg_addr - ADDR_DIODE_NOW);
  wire [15:0] o_pda = 16'(reg_addr - ADDR_DIODE_AVG_PM);
  wire [15:0] o_chn = 16'(reg_addr - ADDR_CHAN_NOW);
  wire [15:0] o_cha = 16'(reg_addr - ADDR_CHAN_AVG_PM);
  wire [15:0] o_pon = 16'(reg_addr - ADDR_POLAR_NOW);
  wire [15:0] o_poa = 16'(reg_addr - ADDR_POLAR_AVG_PM);
  wire [15:0] o_pomin = 16'(reg_addr - ADDR_POLAR_MIN_PM);
  wire [15:0] o_pomax = 16'(reg_addr - ADDR_POLAR_MAX_PM);

  wire h_att = reg_addr >= ADDR_ATTEN_MAX_PM && o_att < 16'(N_ATT);
  wire h_drv = reg_addr >= ADDR_DRIVE_SIGNAL && o_drv < 16'(N_ATT);
  wire h_cmin = reg_addr >= ADDR_CODE_MIN_ATTEN && o_cmin < 16'(N_ATT);
  wire h_cmax = reg_addr >= ADDR_CODE_MAX_ATTEN && o_cmax < 16'(N_ATT);
  wire h_pdn = reg_addr >= ADDR_DIODE_NOW && o_pdn < 16'(N_PD);
  wire h_pda = reg_addr >= ADDR_DIODE_AVG_PM && o_pda < 16'(N_PD);
  wire h_chn = reg_addr >= ADDR_CHAN_NOW && o_chn < 16'(N_CH);
  wire h_cha = reg_addr >= ADDR_CHAN_AVG_PM && o_cha < 16'(N_CH);
  wire h_pon = reg_addr >= ADDR_POLAR_NOW && o_pon < 16'(N_POL);
  wire h_poa = reg_addr >= ADDR_POLAR_AVG_PM && o_poa < 16'(N_POL);
  wire h_pomin = reg_addr >= ADDR_POLAR_MIN_PM && o_pomin < 16'(N_POL);
  wire h_pomax = reg_addr >= ADDR_POLAR_MAX_PM && o_pomax < 16'(N_POL);
  wire h_temp = reg_addr == ADDR_TEMPERATURE;

  // ----------------------------------------------------------------
  // read select
  // ----------------------------------------------------------------
  // windows never overlap, so the priority order carries no meaning

  wire [DW-1:0] rd_mux =
    h_att ? max_pm_r[L_ATT + int'(o_att[0])] :
    h_drv ? drive_r[o_drv[0]] :
    h_cmin ? code_min[o_cmin[0]] :
    h_cmax ? code_max[o_cmax[0]] :
    h_pdn ? now_r[L_PD + int'(o_pdn[2:0])] :
    h_pda ? avg_pm_r[L_PD + int'(o_pda[2:0])] :
    h_chn ? now_r[L_CH + int'(o_chn[1:0])] :
    h_cha ? avg_pm_r[L_CH + int'(o_cha[1:0])] :
    h_pon ? now_r[L_POL + int'(o_pon[0])] :
    h_poa ? avg_pm_r[L_POL + int'(o_poa[0])] :
    h_pomin ? min_pm_r[L_POL + int'(o_pomin[0])] :
    h_pomax ? max_pm_r[L_POL + int'(o_pomax[0])] :
    h_temp ? temp_r :
    UNMAPPED_VALUE;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data holds between reads so a slow host may pick it up late
  wire [DW-1:0] rdata_nxt = reg_rd ? rd_mux : reg_rdata;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= RESET_VALUE;
    end
    else
    begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule : rx_optical_monitor_regs

`default_nettype wire

// >>> rx_optical_monitor_regs_tb_top.sv
// testbench: register, drive and statistics traffic
// assumes the host model on the register port
`timescale 1ns/1ps
`default_nettype none
module rx_optical_monitor_regs_tb_top;
  import rx_mon_pkg::*;
  localparam logic [15:0] LO [2] = '{16'h0100, 16'hf000};
  localparam logic [15:0] HI [2] = '{16'hf000, 16'h0100};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, temp_meas = '0;
  logic reg_wr, reg_rd, reg_rvalid, meas_valid = 1'b0, performance_monitor_interval = 1'b0;
  logic [7:0][15:0] diode_meas = '0;
  logic [1:0][15:0] atten_meas = '0, loop_drive = '0, atten_dac_code;
  logic [1:0] attenuation_closed_loop_enable = '0;
  int error_cnt = 0;
  int n_tests = 0;
  rx_optical_monitor_regs #(.CODE_MIN_ATTEN_0(LO[0]), .CODE_MIN_ATTEN_1(LO[1]), .CODE_MAX_ATTEN_0(HI[0]),
    .CODE_MAX_ATTEN_1(HI[1])) dut (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .meas_valid, .atten_meas, .diode_meas, .temp_meas, .performance_monitor_interval,
    .attenuation_closed_loop_enable, .loop_drive, .atten_dac_code);
  mgmt_host host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
  function automatic int ema_up(input int e, input logic [15:0] x);
    return e + ((int'(x) * (1 << EMA_SHIFT) - e) >>> EMA_SHIFT);
  endfunction : ema_up
  function automatic logic [15:0] sat(input logic [16:0] s);
    return s[16] ? 16'hffff : s[15:0];
  endfunction : sat
  function automatic logic [15:0] ch(input logic [7:0][15:0] d, input int c);
    return sat({1'b0, d[2*c]} + {1'b0, d[2*c+1]});
  endfunction : ch
  function automatic logic [15:0] pol(input logic [7:0][15:0] d, input int p);
    return sat({1'b0, ch(d, 2*p)} + {1'b0, ch(d, 2*p+1)});
  endfunction : pol
  function automatic logic [15:0] dac(input int i, input logic [15:0] d);
    logic [31:0] s;
    s = {16'h0, d} * {16'h0, (HI[i] >= LO[i]) ? HI[i] - LO[i] : LO[i] - HI[i]};
    return (HI[i] >= LO[i]) ? LO[i] + s[31:16] : LO[i] - s[31:16];
  endfunction : dac
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] q;
    host.rd(a, q);
    check(q, e);
  endtask : chk_rd
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #160000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    logic [7:0][15:0] dv;
    logic [1:0][15:0] av, amax, pmin, pmax;
    logic [15:0] tv, d;
    int ema_d [8], ema_c [4], ema_p [2];
    dv = '0;
    tv = '0;
    void'($urandom(32'h549b035a));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 16'hbb9d; a <= 16'hbbc6; a++)
    begin
      d = (a == 16'hbba1 || a == 16'hbba4) ? 16'h0100 : (a == 16'hbba2 || a == 16'hbba3) ? 16'hf000 : 16'h0;
      chk_rd(16'(a), d);
    end
    for (int i = 0; i < 2; i++)
      for (int k = 0; k < 6; k++)
      begin
        d = (k == 0) ? 16'h0000 : 16'($urandom);
        host.wr(ADDR_DRIVE_SIGNAL + 16'(i), d);
        chk_rd(ADDR_DRIVE_SIGNAL + 16'(i), d);
        check(atten_dac_code[i], dac(i, d));
      end
    d = 16'($urandom);
    @(posedge mclk);
    loop_drive[0] <= d;
    attenuation_closed_loop_enable[0] <= 1'b1;
    host.wr(ADDR_DRIVE_SIGNAL, ~d);
    chk_rd(ADDR_DRIVE_SIGNAL, d);
    attenuation_closed_loop_enable[0] <= 1'b0;
    for (int r = 0; r < 3; r++)
    begin
      amax = '0;
      pmin = r == 0 ? '0 : {2{16'hffff}};
      pmax = '0;
      for (int k = 0; k < 2 * r; k++)
      begin
        dv = {$urandom, $urandom, $urandom, $urandom} & {8{(r == 1) ? 16'h3fff : 16'hffff}};
        av = $urandom;
        tv = 16'($urandom);
        @(posedge mclk);
        meas_valid <= 1'b1;
        diode_meas <= dv;
        atten_meas <= av;
        temp_meas <= tv;
        @(posedge mclk);
        meas_valid <= 1'b0;
        for (int p = 0; p < 2; p++)
        begin
          if (pol(dv, p) < pmin[p]) pmin[p] = pol(dv, p);
          if (pol(dv, p) > pmax[p]) pmax[p] = pol(dv, p);
          if (av[p] > amax[p]) amax[p] = av[p];
          ema_p[p] = ema_up(ema_p[p], pol(dv, p));
        end
        for (int i = 0; i < 8; i++)
          ema_d[i] = ema_up(ema_d[i], dv[i]);
        for (int c = 0; c < 4; c++)
          ema_c[c] = ema_up(ema_c[c], ch(dv, c));
      end
      @(posedge mclk);
      performance_monitor_interval <= 1'b1;
      @(posedge mclk);
      performance_monitor_interval <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        chk_rd(ADDR_DIODE_NOW + 16'(i), dv[i]);
        chk_rd(ADDR_DIODE_AVG_PM + 16'(i), 16'(ema_d[i] >> EMA_SHIFT));
      end
      for (int c = 0; c < 4; c++)
      begin
        chk_rd(ADDR_CHAN_NOW + 16'(c), ch(dv, c));
        chk_rd(ADDR_CHAN_AVG_PM + 16'(c), 16'(ema_c[c] >> EMA_SHIFT));
      end
      for (int p = 0; p < 2; p++)
      begin
        chk_rd(ADDR_POLAR_NOW + 16'(p), pol(dv, p));
        chk_rd(ADDR_POLAR_AVG_PM + 16'(p), 16'(ema_p[p] >> EMA_SHIFT));
        chk_rd(ADDR_POLAR_MIN_PM + 16'(p), pmin[p]);
        chk_rd(ADDR_POLAR_MAX_PM + 16'(p), pmax[p]);
        chk_rd(ADDR_ATTEN_MAX_PM + 16'(p), amax[p]);
      end
      host.wr(ADDR_TEMPERATURE, ~tv);
      chk_rd(ADDR_TEMPERATURE, tv);
    end
    close_out();
  end
endmodule : rx_optical_monitor_regs_tb_top
`default_nettype wire
